// >>> hdl/mfr_pkg.sv
package mfr_pkg;

	// ************************************************************
	// Opcodes and link framing
	// ************************************************************
	localparam logic [7:0] OP_QUAD_OUT     = 8'h6B;
	localparam logic [7:0] OP_DUAL_IO      = 8'hBB;
	localparam logic [7:0] OP_QUAD_IO      = 8'hEB;
	localparam logic [7:0] OP_QUAD_WORD    = 8'hE7;
	localparam logic [4:0] OPC_CLKS        = 5'h08;
	localparam logic [4:0] ADDR_CLKS_SGL   = 5'h18;
	localparam logic [4:0] ADDR_CLKS_DUAL  = 5'h0C;
	localparam logic [4:0] ADDR_CLKS_QUAD  = 5'h06;
	localparam logic [4:0] MODE_CLKS_DUAL  = 5'h04;
	localparam logic [4:0] MODE_CLKS_QUAD  = 5'h02;
	localparam logic [4:0] DUMMY_CLKS_QOUT = 5'h08;
	localparam logic [4:0] DUMMY_CLKS_QIO  = 5'h04;
	localparam logic [4:0] DUMMY_CLKS_WORD = 5'h02;
	localparam logic [4:0] BEATS_DUAL      = 5'h04;
	localparam logic [4:0] BEATS_QUAD      = 5'h02;
	localparam logic [3:0] CRST_CLKS       = 4'h8;
	localparam logic [3:0] OE_DUAL         = 4'h3;
	localparam logic [3:0] OE_QUAD         = 4'hF;

	// ************************************************************
	// Continuous mode, wrap and buffering
	// ************************************************************
	localparam int         CONT_PAIR_HI    = 5;
	localparam int         CONT_PAIR_LO    = 4;
	localparam logic [1:0] CONT_ENTER      = 2'h2;
	localparam logic [7:0] WRAP_BASE_MASK  = 8'h08;
	localparam int         BUF_DEPTH       = 2;
	localparam int         ADDR_W          = 24;

	typedef enum logic [2:0] {
		LK_OPCODE = 3'b000,
		LK_ADDR   = 3'b001,
		LK_MODE   = 3'b010,
		LK_DUMMY  = 3'b011,
		LK_DATA   = 3'b100,
		LK_IGNORE = 3'b101
	} mfr_lk_state_t;

	typedef enum logic [1:0] {
		RK_QUAD_OUT  = 2'b00,
		RK_DUAL_IO   = 2'b01,
		RK_QUAD_IO   = 2'b10,
		RK_QUAD_WORD = 2'b11
	} mfr_rd_kind_t;

	typedef enum logic [0:0] {
		FT_IDLE = 1'b0,
		FT_WAIT = 1'b1
	} mfr_fetch_state_t;

	typedef struct packed {
		logic [1:0] wrap_length_select;
		logic       wrap_disable_bit;
	} mfr_wrap_t;

	localparam mfr_wrap_t WRAP_RESET = '{wrap_length_select: 2'h0, wrap_disable_bit: 1'b1};

	typedef struct packed {
		mfr_rd_kind_t kind;
		logic [23:0]  addr;
		logic [7:0]   continuous_mode_byte;
	} mfr_hdr_t;

endpackage : mfr_pkg

// >>> hdl/mfr_fast_read.sv
`timescale 1ns/10ps
module mfr_fast_read #(
	parameter int FIFO_DEPTH = mfr_pkg::BUF_DEPTH
) (
	input  wire logic              ref_clk,           // System clock
	input  wire logic              rst,               // Synchronous reset, active high
	input  wire logic              sclk,              // Link clock from the host
	input  wire logic              cs_n,              // Chip select, active low
	input  wire logic [3:0]        io_in,             // IO3..IO0 pin levels
	output logic      [3:0]        io_out,            // IO3..IO0 driven levels
	output logic      [3:0]        io_oe,             // IO3..IO0 output enables
	input  wire logic              quad_io_enable,    // Status bit nine
	input  wire logic              wrap_load,         // Load pulse for wrap setting
	input  wire mfr_pkg::mfr_wrap_t wrap_setting_bits, // New wrap setting
	output mfr_pkg::mfr_wrap_t     wrap_setting,      // Wrap setting in force
	output logic                   cont_mode_active,  // Continuous mode armed
	output logic                   mem_rd,            // Array read request
	output logic      [23:0]       mem_addr,          // Array read address
	input  wire logic [7:0]        mem_rdata,         // Array read data
	input  wire logic              mem_rvalid         // Array read data valid
);
	import mfr_pkg::*;

	localparam int CW = $clog2(FIFO_DEPTH + 1);
	localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic [4:0] phase_len(input mfr_lk_state_t st, input mfr_rd_kind_t kd);
		logic [4:0] n;
		n = 5'h01;
		case (st)
			LK_OPCODE: n = OPC_CLKS;
			LK_ADDR:   n = (kd == RK_QUAD_OUT) ? ADDR_CLKS_SGL :
			               (kd == RK_DUAL_IO) ? ADDR_CLKS_DUAL : ADDR_CLKS_QUAD;
			LK_MODE:   n = (kd == RK_DUAL_IO) ? MODE_CLKS_DUAL : MODE_CLKS_QUAD;
			LK_DUMMY:  n = (kd == RK_QUAD_OUT) ? DUMMY_CLKS_QOUT :
			               (kd == RK_QUAD_IO) ? DUMMY_CLKS_QIO : DUMMY_CLKS_WORD;
			LK_DATA:   n = (kd == RK_DUAL_IO) ? BEATS_DUAL : BEATS_QUAD;
			default:   n = 5'h01;
		endcase
		return n;
	endfunction : phase_len

	function automatic logic [23:0] shift_in(input logic [23:0] v, input mfr_rd_kind_t kd,
			input logic [3:0] io);
		logic [23:0] r;
		case (kd)
			RK_QUAD_OUT: r = {v[22:0], io[0]};
			RK_DUAL_IO:  r = {v[21:0], io[1:0]};
			default:     r = {v[19:0], io};
		endcase
		return r;
	endfunction : shift_in

	function automatic logic [23:0] next_addr(input logic [23:0] a, input mfr_rd_kind_t kd,
			input mfr_wrap_t w);
		logic [7:0] mask;
		logic [7:0] low;
		mask = 8'((WRAP_BASE_MASK << w.wrap_length_select) - 8'h01);
		low  = a[7:0] + 8'h01;
		if ((kd == RK_QUAD_IO || kd == RK_QUAD_WORD) && !w.wrap_disable_bit) begin
			return {a[23:8], (a[7:0] & ~mask) | (low & mask)};
		end
		return a + 24'h00_0001;
	endfunction : next_addr

	// ************************************************************
	// Ref-domain state, all but wrap_reg read by the link side
	// ************************************************************
	// cont_reg and cont_kind_reg change only after cs_n rises; the link reads them only inside a frame,
	// so the frame edge itself acts as the qualifier.
	logic         qe_reg;
	mfr_wrap_t    wrap_reg;
	logic         cont_reg;
	mfr_rd_kind_t cont_kind_reg;
	logic         req_reg;
	logic [7:0]   hold_reg;

	// ************************************************************
	// Link domain, rising edge: command, address, mode, dummy
	// ************************************************************
	mfr_lk_state_t lk_state_reg, lk_state_next;
	mfr_rd_kind_t  lk_kind_reg, lk_kind_next;
	logic [4:0]    lk_cnt_reg, lk_cnt_next;
	logic          lk_started_reg, lk_started_next;
	logic [7:0]    lk_op_reg, lk_op_next;
	logic [23:0]   lk_addr_reg, lk_addr_next;
	logic [7:0]    lk_mode_reg, lk_mode_next;
	logic          lk_hdr_reg, lk_hdr_next;
	logic [3:0]    lk_clk_reg, lk_clk_next;
	logic          lk_ones_reg, lk_ones_next;
	logic          lk_crst_reg, lk_crst_next;
	logic          lk_ack_reg, lk_ack_next;
	logic [7:0]    lk_byte_reg, lk_byte_next;
	logic          lk_req_s1_reg, lk_req_s2_reg;
	mfr_hdr_t      lk_hdr_bus;

	assign lk_hdr_bus = '{kind: lk_kind_reg, addr: lk_addr_reg, continuous_mode_byte: lk_mode_reg};

	always_comb begin
		mfr_lk_state_t st;
		mfr_rd_kind_t  kd;
		logic          last;
		logic          load;
		logic [23:0]   tmp;
		st = lk_state_reg;
		kd = lk_kind_reg;
		if (!lk_started_reg && cont_reg) begin
			st = LK_ADDR;
			kd = cont_kind_reg;
		end
		last            = (lk_cnt_reg == 5'(phase_len(st, kd) - 5'h01));
		load            = 1'b0;
		tmp             = 24'h00_0000;
		lk_state_next   = st;
		lk_kind_next    = kd;
		lk_cnt_next     = last ? 5'h00 : 5'(lk_cnt_reg + 5'h01);
		lk_started_next = 1'b1;
		lk_op_next      = lk_op_reg;
		lk_addr_next    = lk_addr_reg;
		lk_mode_next    = lk_mode_reg;
		lk_hdr_next     = lk_hdr_reg;
		lk_clk_next     = lk_clk_reg;
		lk_ones_next    = lk_ones_reg;
		lk_crst_next    = lk_crst_reg;
		lk_ack_next     = lk_ack_reg;
		lk_byte_next    = lk_byte_reg;
		if (lk_clk_reg < CRST_CLKS) begin
			lk_clk_next  = 4'(lk_clk_reg + 4'h1);
			lk_ones_next = lk_ones_reg & io_in[0];
			if (lk_clk_reg == 4'(CRST_CLKS - 4'h1) && lk_ones_next) begin
				lk_crst_next = 1'b1;
			end
		end
		case (st)
			LK_OPCODE: begin
				lk_op_next = {lk_op_reg[6:0], io_in[0]};
				if (last) begin
					lk_state_next = LK_ADDR;
					case (lk_op_next)
						OP_QUAD_OUT:  lk_kind_next = RK_QUAD_OUT;
						OP_DUAL_IO:   lk_kind_next = RK_DUAL_IO;
						OP_QUAD_IO:   lk_kind_next = RK_QUAD_IO;
						OP_QUAD_WORD: lk_kind_next = RK_QUAD_WORD;
						default:      lk_state_next = LK_IGNORE;
					endcase
					if ((lk_op_next == OP_QUAD_IO || lk_op_next == OP_QUAD_WORD) && !qe_reg) begin
						lk_state_next = LK_IGNORE;
					end
				end
			end
			LK_ADDR: begin
				lk_addr_next = shift_in(lk_addr_reg, kd, io_in);
				if (last) begin
					lk_state_next = (kd == RK_QUAD_OUT) ? LK_DUMMY : LK_MODE;
					lk_hdr_next   = (kd == RK_QUAD_OUT);
				end
			end
			LK_MODE: begin
				tmp          = shift_in({16'h0000, lk_mode_reg}, kd, io_in);
				lk_mode_next = tmp[7:0];
				if (last) begin
					lk_hdr_next   = 1'b1;
					lk_state_next = (kd == RK_DUAL_IO) ? LK_DATA : LK_DUMMY;
					load          = (kd == RK_DUAL_IO);
				end
			end
			LK_DUMMY: begin
				if (last) begin
					lk_state_next = LK_DATA;
					load          = 1'b1;
				end
			end
			LK_DATA: begin
				load = last;
			end
			default: begin
				lk_cnt_next = lk_cnt_reg;
			end
		endcase
		if (lk_ack_reg && !lk_req_s2_reg) begin
			lk_ack_next = 1'b0;
		end
		if (load) begin
			// No byte waiting means the host clocked faster than the fetch path
			if (lk_req_s2_reg && !lk_ack_reg) begin
				lk_byte_next = hold_reg;
				lk_ack_next  = 1'b1;
			end else begin
				lk_byte_next = 8'h00;
			end
		end
	end

	always_ff @(posedge sclk or posedge cs_n) begin
		if (cs_n) begin
			lk_state_reg   <= LK_OPCODE;
			lk_kind_reg    <= RK_QUAD_OUT;
			lk_cnt_reg     <= 5'h00;
			lk_started_reg <= 1'b0;
			lk_op_reg      <= 8'h00;
			lk_addr_reg    <= 24'h00_0000;
			lk_mode_reg    <= 8'h00;
			lk_hdr_reg     <= 1'b0;
			lk_clk_reg     <= 4'h0;
			lk_ones_reg    <= 1'b1;
			lk_crst_reg    <= 1'b0;
			lk_ack_reg     <= 1'b0;
			lk_byte_reg    <= 8'h00;
			lk_req_s1_reg  <= 1'b0;
			lk_req_s2_reg  <= 1'b0;
		end else begin
			lk_state_reg   <= lk_state_next;
			lk_kind_reg    <= lk_kind_next;
			lk_cnt_reg     <= lk_cnt_next;
			lk_started_reg <= lk_started_next;
			lk_op_reg      <= lk_op_next;
			lk_addr_reg    <= lk_addr_next;
			lk_mode_reg    <= lk_mode_next;
			lk_hdr_reg     <= lk_hdr_next;
			lk_clk_reg     <= lk_clk_next;
			lk_ones_reg    <= lk_ones_next;
			lk_crst_reg    <= lk_crst_next;
			lk_ack_reg     <= lk_ack_next;
			lk_byte_reg    <= lk_byte_next;
			lk_req_s1_reg  <= req_reg;
			lk_req_s2_reg  <= lk_req_s1_reg;
		end
	end

	// ************************************************************
	// Link domain, falling edge: data launch
	// ************************************************************
	logic [3:0] io_out_reg, io_out_next;
	logic [3:0] io_oe_reg, io_oe_next;

	always_comb begin
		io_out_next = 4'h0;
		io_oe_next  = 4'h0;
		if (lk_state_reg == LK_DATA) begin
			if (lk_kind_reg == RK_DUAL_IO) begin
				io_oe_next = OE_DUAL;
				case (lk_cnt_reg[1:0])
					2'h0:    io_out_next = {2'h0, lk_byte_reg[7:6]};
					2'h1:    io_out_next = {2'h0, lk_byte_reg[5:4]};
					2'h2:    io_out_next = {2'h0, lk_byte_reg[3:2]};
					default: io_out_next = {2'h0, lk_byte_reg[1:0]};
				endcase
			end else begin
				io_oe_next  = OE_QUAD;
				io_out_next = lk_cnt_reg[0] ? lk_byte_reg[3:0] : lk_byte_reg[7:4];
			end
		end
	end

	always_ff @(negedge sclk or posedge cs_n) begin
		if (cs_n) begin
			io_out_reg <= 4'h0;
			io_oe_reg  <= 4'h0;
		end else begin
			io_out_reg <= io_out_next;
			io_oe_reg  <= io_oe_next;
		end
	end

	assign io_out = io_out_reg;
	assign io_oe  = io_oe_reg;

	// ************************************************************
	// Ref domain: synchronisers
	// ************************************************************
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic hdr_s1_reg, hdr_s2_reg;
	logic crst_s1_reg, crst_s2_reg;
	logic ack_s1_reg, ack_s2_reg;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cs_s1_reg   <= 1'b1;
			cs_s2_reg   <= 1'b1;
			cs_s3_reg   <= 1'b1;
			hdr_s1_reg  <= 1'b0;
			hdr_s2_reg  <= 1'b0;
			crst_s1_reg <= 1'b0;
			crst_s2_reg <= 1'b0;
			ack_s1_reg  <= 1'b0;
			ack_s2_reg  <= 1'b0;
		end else begin
			cs_s1_reg   <= cs_n;
			cs_s2_reg   <= cs_s1_reg;
			cs_s3_reg   <= cs_s2_reg;
			hdr_s1_reg  <= lk_hdr_reg;
			hdr_s2_reg  <= hdr_s1_reg;
			crst_s1_reg <= lk_crst_reg;
			crst_s2_reg <= crst_s1_reg;
			ack_s1_reg  <= lk_ack_reg;
			ack_s2_reg  <= ack_s1_reg;
		end
	end

	// ************************************************************
	// Ref domain: fetch, two-entry buffer, hand-off to the link
	// ************************************************************
	logic [7:0]       buf_mem_reg [FIFO_DEPTH];
	logic [PW-1:0]    wr_ptr_reg, wr_ptr_next;
	logic [PW-1:0]    rd_ptr_reg, rd_ptr_next;
	logic [CW-1:0]    count_reg, count_next;
	mfr_fetch_state_t ft_state_reg, ft_state_next;
	logic             active_reg, active_next;
	logic             hdr_seen_reg, hdr_seen_next;
	logic             crst_seen_reg, crst_seen_next;
	mfr_rd_kind_t     kind_reg, kind_next;
	logic [1:0]       pair_reg, pair_next;
	logic [23:0]      addr_reg, addr_next;
	logic             mem_rd_reg, mem_rd_next;
	logic [23:0]      mem_addr_reg, mem_addr_next;
	logic             qe_next, cont_next, req_next;
	mfr_wrap_t        wrap_next;
	mfr_rd_kind_t     cont_kind_next;
	logic [7:0]       hold_next;
	logic             in_valid, in_ready, out_valid, out_ready, push, pop, frame_end;

	assign frame_end = cs_s2_reg && !cs_s3_reg;
	assign in_valid  = (ft_state_reg == FT_WAIT) && mem_rvalid;
	assign in_ready  = (count_reg < CW'(FIFO_DEPTH));
	assign out_valid = (count_reg != '0);
	assign out_ready = !req_reg && !ack_s2_reg;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		qe_next        = quad_io_enable;
		wrap_next      = wrap_load ? wrap_setting_bits : wrap_reg;
		cont_next      = cont_reg;
		cont_kind_next = cont_kind_reg;
		req_next       = req_reg;
		hold_next      = hold_reg;
		wr_ptr_next    = wr_ptr_reg;
		rd_ptr_next    = rd_ptr_reg;
		count_next     = CW'(count_reg + CW'(push) - CW'(pop));
		ft_state_next  = ft_state_reg;
		active_next    = active_reg;
		hdr_seen_next  = hdr_seen_reg;
		crst_seen_next = crst_seen_reg | crst_s2_reg;
		kind_next      = kind_reg;
		pair_next      = pair_reg;
		addr_next      = addr_reg;
		mem_rd_next    = mem_rd_reg;
		mem_addr_next  = mem_addr_reg;
		if (push) begin
			wr_ptr_next = (wr_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(wr_ptr_reg + 1'b1);
		end
		if (pop) begin
			rd_ptr_next = (rd_ptr_reg == PW'(FIFO_DEPTH - 1)) ? '0 : PW'(rd_ptr_reg + 1'b1);
			hold_next   = buf_mem_reg[rd_ptr_reg];
			req_next    = 1'b1;
		end else if (req_reg && ack_s2_reg) begin
			req_next = 1'b0;
		end
		if (hdr_s2_reg && !hdr_seen_reg && !cs_s2_reg) begin
			hdr_seen_next = 1'b1;
			active_next   = 1'b1;
			kind_next     = lk_hdr_bus.kind;
			addr_next     = lk_hdr_bus.addr;
			pair_next     = lk_hdr_bus.continuous_mode_byte[CONT_PAIR_HI:CONT_PAIR_LO];
		end
		case (ft_state_reg)
			FT_IDLE: begin
				// A full buffer stalls the next array read
				if (active_reg && in_ready) begin
					mem_rd_next   = 1'b1;
					mem_addr_next = addr_reg;
					ft_state_next = FT_WAIT;
				end
			end
			FT_WAIT: begin
				if (push) begin
					mem_rd_next   = 1'b0;
					addr_next     = next_addr(addr_reg, kind_reg, wrap_reg);
					ft_state_next = FT_IDLE;
				end
			end
			default: ft_state_next = FT_IDLE;
		endcase
		if (frame_end) begin
			if (hdr_seen_reg && kind_reg != RK_QUAD_OUT) begin
				cont_next      = (pair_reg == CONT_ENTER);
				cont_kind_next = kind_reg;
			end else if (crst_seen_reg) begin
				cont_next = 1'b0;
			end
			wr_ptr_next    = '0;
			rd_ptr_next    = '0;
			count_next     = '0;
			req_next       = 1'b0;
			ft_state_next  = FT_IDLE;
			active_next    = 1'b0;
			hdr_seen_next  = 1'b0;
			crst_seen_next = 1'b0;
			mem_rd_next    = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			qe_reg        <= 1'b0;
			wrap_reg      <= WRAP_RESET;
			cont_reg      <= 1'b0;
			cont_kind_reg <= RK_QUAD_OUT;
			req_reg       <= 1'b0;
			hold_reg      <= 8'h00;
			wr_ptr_reg    <= '0;
			rd_ptr_reg    <= '0;
			count_reg     <= '0;
			ft_state_reg  <= FT_IDLE;
			active_reg    <= 1'b0;
			hdr_seen_reg  <= 1'b0;
			crst_seen_reg <= 1'b0;
			kind_reg      <= RK_QUAD_OUT;
			pair_reg      <= 2'h0;
			addr_reg      <= 24'h00_0000;
			mem_rd_reg    <= 1'b0;
			mem_addr_reg  <= 24'h00_0000;
		end else begin
			qe_reg        <= qe_next;
			wrap_reg      <= wrap_next;
			cont_reg      <= cont_next;
			cont_kind_reg <= cont_kind_next;
			req_reg       <= req_next;
			hold_reg      <= hold_next;
			wr_ptr_reg    <= wr_ptr_next;
			rd_ptr_reg    <= rd_ptr_next;
			count_reg     <= count_next;
			ft_state_reg  <= ft_state_next;
			active_reg    <= active_next;
			hdr_seen_reg  <= hdr_seen_next;
			crst_seen_reg <= crst_seen_next;
			kind_reg      <= kind_next;
			pair_reg      <= pair_next;
			addr_reg      <= addr_next;
			mem_rd_reg    <= mem_rd_next;
			mem_addr_reg  <= mem_addr_next;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (push) begin
			buf_mem_reg[wr_ptr_reg] <= mem_rdata;
		end
	end

	assign wrap_setting     = wrap_reg;
	assign cont_mode_active = cont_reg;
	assign mem_rd           = mem_rd_reg;
	assign mem_addr         = mem_addr_reg;

endmodule : mfr_fast_read

// >>> dv/mfr_fast_read_checker.sv
`timescale 1ns/10ps
module mfr_fast_read_checker (
	input wire logic               ref_clk,           // System clock
	input wire logic               rst,               // Sync reset
	input wire logic               cs_n,              // Chip select
	input wire logic [3:0]         io_out,            // Pin drive
	input wire logic [3:0]         io_oe,             // Pin enables
	input wire logic               wrap_load,         // Wrap load
	input wire mfr_pkg::mfr_wrap_t wrap_setting_bits, // New wrap
	input wire mfr_pkg::mfr_wrap_t wrap_setting,      // Wrap in force
	input wire logic               cont_mode_active,  // Mode armed
	input wire logic               mem_rd,            // Fetch request
	input wire logic [23:0]        mem_addr,          // Fetch address
	input wire logic               mem_rvalid         // Fetch answer
);
	import mfr_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	logic [23:0] last_reg;
	logic        seen_reg;
	// Step check only inside one frame; a new frame restarts anywhere
	always_ff @(posedge ref_clk) begin
		seen_reg <= !(rst || cs_n) && (seen_reg || (mem_rd && mem_rvalid));
		last_reg <= (mem_rd && mem_rvalid) ? mem_addr : last_reg;
	end
	// ********************
	// Link, fetch, wrap setting and continuous mode checks
	// ********************
	a_oe_legal: assert property (io_oe inside {4'h0, 4'h3, 4'hF})
		else $error("io_oe pattern illegal");
	a_oe_idle: assert property (cs_n && $past(cs_n) |-> io_oe == 4'h0)
		else $error("io_oe set while deselected");
	a_out_quiet: assert property (io_oe == 4'h0 |-> io_out == 4'h0)
		else $error("io_out set without enable");
	a_wrap_load: assert property (wrap_load |=> wrap_setting == $past(wrap_setting_bits))
		else $error("wrap setting not loaded");
	a_wrap_keep: assert property (!wrap_load |=> $stable(wrap_setting))
		else $error("wrap setting changed unasked");
	a_rst_vals: assert property ($fell(rst) |-> !mem_rd && !cont_mode_active
		&& wrap_setting == WRAP_RESET) else $error("reset values wrong");
	// A frame end may cancel an open request, so only mid-frame requests must hold
	a_rd_hold: assert property (mem_rd && !mem_rvalid && !cs_n && !$past(cs_n) |=> mem_rd
		&& $stable(mem_addr)) else $error("fetch request dropped early");
	a_rd_drop: assert property (mem_rd && mem_rvalid |=> !mem_rd)
		else $error("fetch request held after answer");
	a_addr_step: assert property ($rose(mem_rd) && seen_reg |->
		mem_addr == last_reg + 24'h00_0001
		|| (!wrap_setting.wrap_disable_bit && mem_addr[23:6] == last_reg[23:6]))
		else $error("fetch address step wrong");
	a_cont_end: assert property ($changed(cont_mode_active) |-> cs_n)
		else $error("continuous mode changed mid frame");
endmodule : mfr_fast_read_checker

// >>> dv/mfr_host_model.sv
`timescale 1ns/10ps
module mfr_host_model (
	output logic            sclk,   // Link clock
	output logic            cs_n,   // Chip select
	output logic      [3:0] io_in,  // Resolved pins
	input  wire logic [3:0] io_out, // Device drive
	input  wire logic [3:0] io_oe   // Device enables
);
	logic [3:0] drv;
	logic [3:0] en;
	logic [3:0] oe_seen;
	logic       tog;
	logic [7:0] acc;
	logic [7:0] rx_q[$];
	int         nb;
	// Undriven lines toggle so a stale level never passes
	assign io_in = (io_oe & io_out) | (~io_oe & en & drv) | (~io_oe & ~en & {4{tog}});
	initial begin
		sclk = 1'b0;
		cs_n = 1'b0;
		drv  = 4'h0;
		en   = 4'h0;
		tog  = 1'b0;
		// Rising select clears the link side before the first frame
		#1 cs_n = 1'b1;
	end
	task automatic tick();
		#7.5 sclk = 1'b1;
		oe_seen = oe_seen | io_oe;
		if (io_oe != 4'h0) begin
			acc = (io_oe == 4'hF) ? {acc[3:0], io_out} : {acc[5:0], io_out[1:0]};
			nb  = nb + ((io_oe == 4'hF) ? 4 : 2);
			if (nb == 8) begin
				rx_q.push_back(acc);
				nb = 0;
			end
		end
		#7.5 sclk = 1'b0;
		tog = ~tog;
	endtask : tick
	task automatic put(input logic [31:0] v, input int bits, input int w);
		logic [31:0] sh;
		sh = v << (32 - bits);
		en = 4'hF >> (4 - w);
		for (int i = 0; i < bits / w; i++) begin
			drv = sh[31:28] >> (4 - w);
			sh = sh << w;
			tick();
		end
	endtask : put
	task automatic frame(input logic op_en, input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] m, input int w, input int dum);
		oe_seen = 4'h0;
		nb      = 0;
		rx_q.delete();
		cs_n    = 1'b0;
		if (op_en) put(32'(op), 8, 1);
		put(32'(a), 24, w);
		if (w > 1) put(32'(m), 8, w);
		put(32'h0000_0000, dum * w, w);
		en = 4'h0;
		repeat (300) tick();
		#400 cs_n = 1'b1;
		#600;
	endtask : frame
	task automatic crst();
		cs_n = 1'b0;
		put(32'h0000_00FF, 8, 1);
		en = 4'h0;
		#400 cs_n = 1'b1;
		#600;
	endtask : crst
endmodule : mfr_host_model

// >>> dv/mfr_fast_read_test.sv
`timescale 1ns/10ps
module mfr_fast_read_test;
	import mfr_pkg::*;
	logic        ref_clk, rst, sclk, cs_n, quad_io_enable, wrap_load;
	logic        cont_mode_active, mem_rd, mem_rvalid;
	logic [3:0]  io_in, io_out, io_oe;
	logic [7:0]  mem_rdata;
	logic [23:0] mem_addr;
	logic [1:0]  lat, wlen;
	logic [31:0] seed;
	logic [23:0] addr_q[$];
	logic [7:0]  data_q[$];
	mfr_wrap_t   wrap_setting_bits, wrap_setting;
	int          failures, samples_checked;
	mfr_fast_read dut_u (.ref_clk, .rst, .sclk, .cs_n, .io_in, .io_out, .io_oe, .quad_io_enable,
		.wrap_load, .wrap_setting_bits, .wrap_setting, .cont_mode_active, .mem_rd, .mem_addr,
		.mem_rdata, .mem_rvalid);
	mfr_host_model host_u (.sclk, .cs_n, .io_in, .io_out, .io_oe);
	always #50 ref_clk = ~ref_clk;
	// Array answers with a varying latency of one to four cycles
	always @(posedge ref_clk) begin
		mem_rvalid <= 1'b0;
		if (mem_rd && !mem_rvalid) begin
			lat <= lat - 2'h1;
			if (lat == 2'h0) begin
				mem_rvalid <= 1'b1;
				mem_rdata  <= 8'(rnd());
				lat        <= mem_addr[1:0];
				addr_q.push_back(mem_addr);
				data_q.push_back(8'(seed));
			end
		end
	end
	function automatic logic [23:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[23:0];
	endfunction : rnd
	function automatic logic [23:0] nxt(input logic [23:0] a, input logic wr);
		logic [23:0] m;
		m = (24'h00_0008 << wlen) - 24'h00_0001;
		return wr ? (a & ~m) | ((a + 24'h00_0001) & m) : a + 24'h00_0001;
	endfunction : nxt
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic end_sim();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : end_sim
	task automatic wl(input mfr_wrap_t b);
		@(posedge ref_clk);
		wrap_load         <= 1'b1;
		wrap_setting_bits <= b;
		@(posedge ref_clk);
		wrap_load <= 1'b0;
		@(posedge ref_clk);
		check(wrap_setting, b);
	endtask : wl
	task automatic rd(input logic op_en, input logic [7:0] op, input logic [23:0] a,
		input logic [7:0] m, input int w, input int dum, input logic [3:0] oe, input logic wr);
		logic [23:0] e;
		int          p;
		e = a;
		p = 0;
		addr_q.delete();
		data_q.delete();
		host_u.frame(op_en, op, a, m, w, dum);
		check(host_u.oe_seen, oe);
		// Underrun bytes are zero, so only non-zero bytes are matched in order
		for (int j = 0; j < host_u.rx_q.size(); j++) begin
			if (host_u.rx_q[j] != 8'h00) begin
				while (p < data_q.size() && data_q[p] == 8'h00) p++;
				check(host_u.rx_q[j], data_q[p]);
				p++;
			end
		end
		if (oe == 4'h0) check(addr_q.size(), 0);
		for (int i = 0; i < (oe != 4'h0 ? 6 : 0); i++) begin
			check(addr_q[i], e);
			e = nxt(e, wr);
		end
	endtask : rd
	// ********************
	// Main sequence
	// ********************
	initial begin
		ref_clk           = 1'b0;
		rst               = 1'b1;
		quad_io_enable    = 1'b0;
		wrap_load         = 1'b0;
		wrap_setting_bits = WRAP_RESET;
		mem_rvalid        = 1'b0;
		mem_rdata         = 8'h00;
		lat               = 2'h0;
		wlen              = 2'h0;
		seed              = 32'h0000_5fc9;
		failures          = 0;
		samples_checked   = 0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check(wrap_setting, 3'b001);
		rd(1, OP_QUAD_IO, rnd(), 8'h20, 4, 4, 4'h0, 0);
		check(cont_mode_active, 0);
		rd(1, OP_QUAD_OUT, rnd(), 8'h00, 1, 8, 4'hF, 0);
		@(posedge ref_clk) quad_io_enable <= 1'b1;
		rd(1, OP_DUAL_IO, rnd(), 8'hA5, 2, 0, 4'h3, 0);
		check(cont_mode_active, 1);
		rd(0, 8'h00, rnd(), 8'h00, 2, 0, 4'h3, 0);
		check(cont_mode_active, 0);
		for (int k = 0; k < 4; k++) begin
			wlen = k[1:0];
			wl({wlen, 1'b0});
			rd(1, k[0] ? OP_QUAD_WORD : OP_QUAD_IO, (rnd() & 24'hFF_FFC0) | 24'h00_003C,
				8'(rnd()) & 8'hCF | 8'h10, 4, k[0] ? 2 : 4, 4'hF, 1);
		end
		wl({2'(rnd()), 1'b1});
		rd(1, OP_QUAD_IO, rnd() | 24'h00_003C, 8'h00, 4, 4, 4'hF, 0);
		rd(1, OP_QUAD_WORD, rnd() & 24'hFF_FFFE, 8'(rnd()) & 8'hCF | 8'h20, 4, 2, 4'hF, 0);
		check(cont_mode_active, 1);
		host_u.crst();
		check(cont_mode_active, 0);
		rd(1, OP_DUAL_IO, rnd(), 8'h20, 2, 0, 4'h3, 0);
		check(cont_mode_active, 1);
		host_u.crst();
		check(cont_mode_active, 0);
		end_sim();
	end
	initial begin
		#2_000_000;
		failures++;
		end_sim();
	end
endmodule : mfr_fast_read_test
bind mfr_fast_read mfr_fast_read_checker chk_u (.ref_clk, .rst, .cs_n, .io_out, .io_oe,
	.wrap_load, .wrap_setting_bits, .wrap_setting, .cont_mode_active, .mem_rd, .mem_addr,
	.mem_rvalid);
